// ===== design/ifmv_top.sv
// Interrupt flags, masks, global enable, vector and halt release
//
// Behaviour
// - Six sources, two ports, three timer taps, remote, each individually masked.
// - Disable instruction clears the global flag, blocking every request.
// - Accepted interrupt releases halt; halt with all disabled needs watchdog reset.
// - Port-0 flag sets on any falling edge of the four port-0 lines.
// - Port-1 flag sets on any falling edge of the four port-1 lines.
// - Remote flag sets when the interval counter borrows to fifteen.
// - 32 Hz flag sets on falling edge of the 32 Hz tap.
// - 8 Hz flag sets on falling edge of the 8 Hz tap.
// - 2 Hz flag sets on falling edge of the 2 Hz tap.
// - Flags are read-only and reading an address clears all its flags.
// - Request when mask, flag and global enable are all one.
// - Reset clears masks, flags, forced output, timer run; carrier on.
// - Vector loads page one, upper eight bits fixed, step one to fifteen.
// - Low four step bits show port-0, port-1, remote and any timer.
// - Timers share one vector bit; software reads flags to tell rates.
// - Port-0 plus timer gives step nine, remote alone gives four.
// - No hardware priority among simultaneous sources.
// - Acceptance clears the global flag, leaving interrupts disabled.
// - Writing one to watchdog clear bit pulses a clear, stores nothing.
// - Timer run bit runs or stops timer; forced remote output bit.
// - Requests are level sensitive and retaken while flag and mask stay set.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "ifmv_map.svh"

module ifmv_top
  import ifmv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_dat_i,
  output logic [3:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [0:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [3:0] port0_inputs_i,
  input wire logic [3:0] port1_inputs_i,
  input wire logic tap_32hz_i,
  input wire logic tap_8hz_i,
  input wire logic tap_2hz_i,
  input wire logic remote_borrow_i,
  input wire logic di_exec_i,
  input wire logic ei_exec_i,
  input wire logic halt_exec_i,
  input wire logic accept_ready_i,
  output logic irq_o,
  output logic accept_o,
  output logic [11:0] vector_o,
  output logic halted_o,
  output logic watchdog_clear_o,
  output logic timer_run_o,
  output logic forced_remote_output_o,
  output logic carrier_generator_on_o
);
  import ifmv_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic ack_q;
  logic [3:0] dat_q;
  wire access_w = wb_cyc_i && wb_stb_i && !ack_q;
  // Writes land on the edge where the master samples ack high
  wire done_w = wb_cyc_i && wb_stb_i && ack_q;
  wire wr_w = done_w && wb_we_i && wb_sel_i[0];
  wire rd_w = access_w && !wb_we_i;
  wire sel_f0 = wb_adr_i == `IFMV_OFS_FLAGS0;
  wire sel_f1 = wb_adr_i == `IFMV_OFS_FLAGS1;
  wire sel_m0 = wb_adr_i == `IFMV_OFS_MASK0;
  wire sel_m1 = wb_adr_i == `IFMV_OFS_MASK1;
  wire sel_gl = wb_adr_i == `IFMV_OFS_GLOBAL;
  wire sel_vc = wb_adr_i == `IFMV_OFS_VECTOR;
  wire rd_clr0 = rd_w && sel_f0;
  wire rd_clr1 = rd_w && sel_f1;

  // ****************************************
  // Edge detection
  // ****************************************
  logic [3:0] p0_q;
  logic [3:0] p1_q;
  logic [2:0] tap_q;
  wire [2:0] tap_w = {tap_2hz_i, tap_8hz_i, tap_32hz_i};
  wire p0_fall = |(p0_q & ~port0_inputs_i);
  wire p1_fall = |(p1_q & ~port1_inputs_i);
  wire [2:0] tap_fall = tap_q & ~tap_w;

  // ****************************************
  // Flags and masks
  // ****************************************
  logic [2:0] flag0_q;
  logic [2:0] flag1_q;
  logic [2:0] mask0_q;
  logic [2:0] mask1_q;
  logic global_q;
  logic forced_q;
  logic carrier_q;
  logic run_q;
  logic wdc_q;
  wire [2:0] set0 = {remote_borrow_i, p1_fall, p0_fall};
  // Set wins over the read clear so an event is never lost
  wire [2:0] flag0_d = (rd_clr0 ? 3'h0 : flag0_q) | set0;
  wire [2:0] flag1_d = (rd_clr1 ? 3'h0 : flag1_q) | tap_fall;
  wire [2:0] act0 = flag0_q & mask0_q;
  wire [2:0] act1 = flag1_q & mask1_q;
  wire pending = |{act0, act1};
  wire req_w = pending && global_q;
  wire take_w = req_w && accept_ready_i && !accept_o;
  // One timer bit for all three rates, no priority encoding
  wire [3:0] step_w = {|act1, act0};

  // ****************************************
  // Core state
  // ****************************************
  ifmv_core_t state_q;
  ifmv_core_t state_d;
  logic halted_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      IFMV_RUN: begin
        if (halt_exec_i) begin
          state_d = IFMV_HALT;
        end
      end
      IFMV_HALT: begin
        // With everything disabled only a watchdog reset leaves halt
        if (take_w) begin
          state_d = IFMV_RUN;
        end
      end
      default: begin
        state_d = IFMV_RUN;
      end
    endcase
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [3:0] rdata_w;
  always_comb begin
    rdata_w = 4'h0;
    if (sel_f0) begin
      rdata_w = {forced_q, flag0_q};
    end else if (sel_f1) begin
      rdata_w = {1'b0, flag1_q};
    end else if (sel_m0) begin
      rdata_w = {carrier_q, mask0_q};
    end else if (sel_m1) begin
      rdata_w = {run_q, mask1_q};
    end else if (sel_gl) begin
      rdata_w = {3'h0, global_q};
    end else if (sel_vc) begin
      rdata_w = vector_o[3:0];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 4'h0;
      p0_q <= 4'hF;
      p1_q <= 4'hF;
      tap_q <= 3'h0;
      flag0_q <= 3'h0;
      flag1_q <= 3'h0;
      mask0_q <= `IFMV_RST_MASK;
      mask1_q <= `IFMV_RST_MASK;
      global_q <= 1'b0;
      forced_q <= 1'b0;
      carrier_q <= `IFMV_RST_CARRIER;
      run_q <= 1'b0;
      wdc_q <= 1'b0;
      state_q <= IFMV_RUN;
      halted_q <= 1'b0;
      irq_o <= 1'b0;
      accept_o <= 1'b0;
      vector_o <= 12'h000;
    end else begin
      ack_q <= access_w;
      dat_q <= rd_w ? rdata_w : 4'h0;
      p0_q <= port0_inputs_i;
      p1_q <= port1_inputs_i;
      tap_q <= tap_w;
      flag0_q <= flag0_d;
      flag1_q <= flag1_d;
      wdc_q <= wr_w && sel_f1 && wb_dat_i[`IFMV_BIT_D3];
      if (wr_w && sel_f0) begin
        forced_q <= wb_dat_i[`IFMV_BIT_D3];
      end
      if (wr_w && sel_m0) begin
        mask0_q <= wb_dat_i[2:0];
        carrier_q <= wb_dat_i[`IFMV_BIT_D3];
      end
      if (wr_w && sel_m1) begin
        mask1_q <= wb_dat_i[2:0];
        run_q <= wb_dat_i[`IFMV_BIT_D3];
      end
      // Accept outranks enable; the core re-enables after service
      if (take_w || di_exec_i) begin
        global_q <= 1'b0;
      end else if (ei_exec_i || (wr_w && sel_gl)) begin
        global_q <= ei_exec_i ? 1'b1 : wb_dat_i[0];
      end
      state_q <= state_d;
      halted_q <= state_d == IFMV_HALT;
      irq_o <= req_w;
      accept_o <= take_w;
      if (take_w) begin
        vector_o <= {`IFMV_PAGE, `IFMV_STEP_HI, step_w};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign halted_o = halted_q;
  assign watchdog_clear_o = wdc_q;
  assign timer_run_o = run_q;
  assign forced_remote_output_o = forced_q;
  assign carrier_generator_on_o = carrier_q;
endmodule
`default_nettype wire

// ===== pkg/ifmv_map.svh
// Register offsets, field positions, reset values and vector constants
`ifndef IFMV_MAP_SVH
`define IFMV_MAP_SVH
`define IFMV_OFS_FLAGS0 8'hF0
`define IFMV_OFS_FLAGS1 8'hF1
`define IFMV_OFS_MASK0 8'hF2
`define IFMV_OFS_MASK1 8'hF3
`define IFMV_OFS_GLOBAL 8'hF4
`define IFMV_OFS_VECTOR 8'hF5
`define IFMV_BIT_D3 3
`define IFMV_RST_MASK 3'h0
`define IFMV_RST_CARRIER 1'h1
`define IFMV_PAGE 4'h1
`define IFMV_STEP_HI 4'h0
`endif

// ===== pkg/ifmv_pkg.sv
// Types shared by the interrupt flag, mask and vector block
package ifmv_pkg;
  typedef enum logic [1:0] {
    IFMV_RUN,
    IFMV_HALT
  } ifmv_core_t;
endpackage

// ===== test/ifmv_core_model.sv
// Core sequencer model for interrupt acceptance
`timescale 1ns/10ps
`default_nettype none
module ifmv_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic accept_ready_o
);
  logic tick_q;
  // Slow mode stands for a core busy on long instructions
  always_ff @(posedge clk_i) tick_q <= rst_i ? 1'b0 : !tick_q;
  assign accept_ready_o = !slow_i || tick_q;
endmodule
`default_nettype wire

// ===== test/ifmv_properties.sv
// Port checks for the interrupt block
`timescale 1ns/10ps
`default_nettype none
module ifmv_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic di_exec_i,
  input wire logic irq_o,
  input wire logic accept_o,
  input wire logic [11:0] vector_o,
  input wire logic halted_o,
  input wire logic carrier_generator_on_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack wrong");
  property p_page; accept_o |-> vector_o[11:4] == 8'h10 && vector_o[3:0] != 4'h0; endproperty
  a_page: assert property (p_page) else $error("vector page wrong");
  property p_once; accept_o |=> !accept_o; endproperty
  a_once: assert property (p_once) else $error("accept held");
  property p_clear; accept_o |=> !irq_o; endproperty
  a_clear: assert property (p_clear) else $error("irq after accept");
  property p_di; di_exec_i |=> ##1 !irq_o; endproperty
  a_di: assert property (p_di) else $error("irq after disable");
  property p_wake; accept_o |-> ##[0:1] !halted_o; endproperty
  a_wake: assert property (p_wake) else $error("halt kept");
  property p_rst; $past(rst_i) |-> carrier_generator_on_o && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_vec; $changed(vector_o) |-> accept_o; endproperty
  a_vec: assert property (p_vec) else $error("vector moved");
endmodule
bind ifmv_top ifmv_properties ifmv_properties_inst (.*);
`default_nettype wire

// ===== test/ifmv_top_tb.sv
// Self-checking bench for the interrupt block
`timescale 1ns/10ps
`default_nettype none
module ifmv_top_tb;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, slow = 0;
  logic tap_32hz_i = 1, tap_8hz_i = 1, tap_2hz_i = 1, remote_borrow_i = 0, di_exec_i = 0;
  logic ei_exec_i = 0, halt_exec_i = 0, accept_ready_i, irq_o, accept_o, halted_o;
  logic watchdog_clear_o, timer_run_o, forced_remote_output_o, carrier_generator_on_o;
  logic [0:0] wb_sel_i = 1'h1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_dat_i = 4'h0, wb_dat_o, q, port0_inputs_i = 4'hF, port1_inputs_i = 4'hF;
  logic [11:0] vector_o;
  int n_errors = 0, n_compared = 0, ticks = 0;
  ifmv_top ifmv_top_inst (.*);
  ifmv_core_model ifmv_core_model_inst (.clk_i, .rst_i, .slow_i(slow),
    .accept_ready_o(accept_ready_i));
  initial forever #10 clk_i = !clk_i;
  always @(posedge clk_i) if (ticks++ == 2000) begin
    n_errors++;
    complete_run();
  end
  task automatic chk(input logic [11:0] s, e, input string nm);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] d);
    {wb_we_i, wb_adr_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {w, a, d, 2'h3};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [3:0] e, input string nm);
    bus(1'b0, a, 4'h0);
    chk(12'(q), 12'(e), nm);
  endtask
  // Falls on ports and taps, borrow pulse, then lines back idle
  task automatic evt(input logic [10:0] v, input logic r);
    {port1_inputs_i, port0_inputs_i, tap_2hz_i, tap_8hz_i, tap_32hz_i} <= ~v;
    remote_borrow_i <= r;
    @(posedge clk_i);
    {port1_inputs_i, port0_inputs_i, tap_2hz_i, tap_8hz_i, tap_32hz_i} <= 11'h7FF;
    remote_borrow_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic go(input logic [2:0] v);
    {di_exec_i, ei_exec_i, halt_exec_i} <= v;
    @(posedge clk_i);
    {di_exec_i, ei_exec_i, halt_exec_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic wacc(input logic [11:0] e);
    while (accept_o !== 1'b1) @(posedge clk_i);
    chk(vector_o, e, "vector");
    @(posedge clk_i);
  endtask
  task automatic t_flags();
    rdc(8'hF2, 4'h8, "masks");
    rdc(8'hF3, 4'h0, "run");
    rdc(8'hE0, 4'h0, "unmapped");
    evt({4'h8, 4'h2, 3'h0}, 1'b1);
    rdc(8'hF0, 4'h7, "port flags");
    rdc(8'hF0, 4'h0, "cleared");
    evt(11'h007, 1'b0);
    bus(1'b1, 8'hF1, 4'h0);
    rdc(8'hF1, 4'h7, "timer flags");
    rdc(8'hF1, 4'h0, "cleared");
    bus(1'b1, 8'hF1, 4'h8);
    chk(12'(watchdog_clear_o), 12'h1, "watchdog clear");
    rdc(8'hF1, 4'h0, "clear not stored");
    bus(1'b1, 8'hF0, 4'h8);
    chk(12'(forced_remote_output_o), 12'h1, "forced output");
    bus(1'b1, 8'hF3, 4'h8);
    chk(12'(timer_run_o), 12'h1, "timer run");
    $display("flag test done");
  endtask
  task automatic t_vector();
    evt({4'h0, 4'h4, 3'h4}, 1'b0);
    bus(1'b1, 8'hF2, 4'h9);
    bus(1'b1, 8'hF3, 4'h4);
    bus(1'b1, 8'hF4, 4'h1);
    wacc(12'h109);
    rdc(8'hF4, 4'h0, "global");
    slow <= 1'b1;
    bus(1'b1, 8'hF4, 4'h1);
    wacc(12'h109);
    bus(1'b0, 8'hF0, 4'h0);
    bus(1'b0, 8'hF1, 4'h0);
    $display("vector test done");
  endtask
  task automatic t_halt();
    bus(1'b1, 8'hF2, 4'hC);
    evt(11'h000, 1'b1);
    go(3'h1);
    chk(12'(halted_o), 12'h1, "halted");
    go(3'h2);
    wacc(12'h104);
    chk(12'(halted_o), 12'h0, "woken");
    go(3'h6);
    rdc(8'hF4, 4'h0, "blocked");
    $display("halt test done");
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_flags();
    t_vector();
    t_halt();
    complete_run();
  end
endmodule
`default_nettype wire
